// ==== rtl/alarm_indicator_defines.vh ====
/*
 * constants for the alarm indicator and fault code block: range limits in
 * tenths of a degree, fault code numbers, timing counts.
 * assumes a 40 mhz clock; readings are signed tenths of a degree celsius.
 */
`ifndef ALARM_INDICATOR_DEFINES_VH
`define ALARM_INDICATOR_DEFINES_VH

`define TEMP_W            16
`define RANGE_MIN_TENTHS  16'shfe0c
`define RANGE_MAX_TENTHS  16'sh07d0
`define CODE_NONE         4'h0
`define CODE_OVER_RANGE   4'h1
`define CODE_UNDER_RANGE  4'h2
`define CODE_SYSTEM       4'h7
`define CODE_SENSOR       4'h9
`define CLK_HZ            40000000
`define SAMPLES_PER_SEC   4
`define SAMPLE_CYCLES     (`CLK_HZ / `SAMPLES_PER_SEC)
`define SECOND_CYCLES     `CLK_HZ
`define DELAY_W           8

`endif

// ==== rtl/alarm_indicator.v ====
/*
 * alarm led and fault code logic of a panel temperature meter: fault code
 * selection, display mode, delayed limit alarms and the three alarm leds.
 * assumes readings arrive synchronous to clk_in as signed tenths of a degree,
 * with sensor and self-test fault levels supplied by the front end.
 */
`timescale 1ns/1ps
`include "alarm_indicator_defines.vh"

module alarm_indicator #(
    // pacing counts; hardware keeps the defaults, a bench may shorten them
    parameter SAMPLE_CYCLES = `SAMPLE_CYCLES,
    parameter SECOND_CYCLES = `SECOND_CYCLES
) (
    // clock and reset
    input  wire                        clk_in,
    input  wire                        arst_n_in,
    // measurement front end
    input  wire signed [`TEMP_W-1:0]   reading_in,
    input  wire                        sensor_fault_in,
    input  wire                        self_test_fail_in,
    // configuration
    input  wire                        minmax_alarm_output_function_in,
    input  wire signed [`TEMP_W-1:0]   upper_alarm_limit_in,
    input  wire signed [`TEMP_W-1:0]   lower_alarm_limit_in,
    input  wire [`DELAY_W-1:0]         alarm_delay_seconds_in,
    // indicators
    output wire                        led_alarm_out,
    output wire                        led_min_out,
    output wire                        led_max_out,
    // display
    output reg  [3:0]                  fault_code_out,
    output reg                         show_code_out,
    output reg  signed [`TEMP_W-1:0]   display_value_out,
    output reg                         sample_tick_out
);

    localparam [31:0] SAMPLE_LAST = SAMPLE_CYCLES - 1;
    localparam [31:0] SECOND_LAST = SECOND_CYCLES - 1;
    localparam        CH_LOW      = 0;
    localparam        CH_HIGH     = 1;
    localparam        SRC_SYSTEM  = 0;
    localparam        SRC_SENSOR  = 1;
    localparam        SRC_OVER    = 2;
    localparam        SRC_UNDER   = 3;
    localparam [0:0]  MODE_VALUE  = 1'b0;
    localparam [0:0]  MODE_CODE   = 1'b1;

    // reset release: two flops so every register leaves reset on the same edge
    reg        rst_meta_q;
    reg        rst_sync_q;
    wire       rst_n;

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
        end
    end

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync_q <= 1'b0;
        end else begin
            rst_sync_q <= rst_meta_q;
        end
    end

    assign rst_n = rst_sync_q;

    // sample pacing; readings, fault levels and limits are only looked at on this tick, so changes
    // between samples are ignored on purpose
    reg  [31:0] sample_cnt_q;
    wire        sample_tick;

    assign sample_tick = (sample_cnt_q == SAMPLE_LAST);

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sample_cnt_q <= 32'h0;
        end else if (sample_tick) begin
            sample_cnt_q <= 32'h0;
        end else begin
            sample_cnt_q <= sample_cnt_q + 32'h1;
        end
    end

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sample_tick_out <= 1'b0;
        end else begin
            sample_tick_out <= sample_tick;
        end
    end

    // one-second tick, free running; a delay is therefore whole seconds
    // with up to one second of slack at its start
    reg  [31:0] sec_cnt_q;
    wire        sec_tick;

    assign sec_tick = (sec_cnt_q == SECOND_LAST);

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sec_cnt_q <= 32'h0;
        end else if (sec_tick) begin
            sec_cnt_q <= 32'h0;
        end else begin
            sec_cnt_q <= sec_cnt_q + 32'h1;
        end
    end

    // measuring span checks
    function over_span;
        input signed [`TEMP_W-1:0] val;
        begin
            over_span = (val > `RANGE_MAX_TENTHS);
        end
    endfunction

    function under_span;
        input signed [`TEMP_W-1:0] val;
        begin
            under_span = (val < `RANGE_MIN_TENTHS);
        end
    endfunction

    // fault sources in priority order, lowest index wins
    wire [3:0] src_hit;

    assign src_hit[SRC_SYSTEM] = self_test_fail_in;
    assign src_hit[SRC_SENSOR] = sensor_fault_in;
    assign src_hit[SRC_OVER]   = over_span(reading_in);
    assign src_hit[SRC_UNDER]  = under_span(reading_in);

    // fault code priority: device error, sensor, then range
    function [3:0] pick_code;
        input [3:0] hit;
        begin
            if (hit[SRC_SYSTEM]) begin
                pick_code = `CODE_SYSTEM;
            end else if (hit[SRC_SENSOR]) begin
                pick_code = `CODE_SENSOR;
            end else if (hit[SRC_OVER]) begin
                pick_code = `CODE_OVER_RANGE;
            end else if (hit[SRC_UNDER]) begin
                pick_code = `CODE_UNDER_RANGE;
            end else begin
                pick_code = `CODE_NONE;
            end
        end
    endfunction

    // limit comparison, shared by both alarm channels
    function beyond;
        input signed [`TEMP_W-1:0] val;
        input signed [`TEMP_W-1:0] lim;
        input                      upward;
        begin
            if (upward) begin
                beyond = (val > lim);
            end else begin
                beyond = (val < lim);
            end
        end
    endfunction

    wire [3:0] code_d;
    wire       code_active;

    assign code_d      = pick_code(src_hit);
    assign code_active = (code_d != `CODE_NONE);

    // code is recomputed each sample so range codes drop out by themselves
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            fault_code_out <= `CODE_NONE;
        end else if (sample_tick) begin
            fault_code_out <= code_d;
        end
    end

    // display mode; it flips only on a sample so code and value never mix
    reg [0:0] mode_d;

    always @* begin
        mode_d = show_code_out;
        case (show_code_out)
            MODE_VALUE: begin
                if (sample_tick && code_active) begin
                    mode_d = MODE_CODE;
                end
            end
            MODE_CODE: begin
                if (sample_tick && !code_active) begin
                    mode_d = MODE_VALUE;
                end
            end
            default: begin
                mode_d = MODE_VALUE;
            end
        endcase
    end

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            show_code_out <= MODE_VALUE;
        end else begin
            show_code_out <= mode_d;
        end
    end

    // the last good reading is held while a code covers the display
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            display_value_out <= {`TEMP_W{1'b0}};
        end else if (sample_tick && !code_active) begin
            display_value_out <= reading_in;
        end
    end

    // limit alarm channels: index 0 watches the low limit, 1 the high limit
    wire [1:0] chan_lit;
    wire       sys_alarm;

    // range codes light the leds too: a reading the meter cannot trust
    // is handled like a system fault
    assign sys_alarm = show_code_out;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_limit
            wire signed [`TEMP_W-1:0] limit;
            wire                      secs_full;
            wire                      delay_met;
            reg                       past_q;
            reg  [`DELAY_W-1:0]       secs_q;
            reg                       alarm_q;

            assign limit     = (ch == CH_HIGH) ? upper_alarm_limit_in
                                               : lower_alarm_limit_in;
            assign secs_full = (secs_q == {`DELAY_W{1'b1}});
            assign delay_met = (secs_q >= alarm_delay_seconds_in);

            // excursion flag follows the sample rate like the codes do
            always @(posedge clk_in or negedge rst_n) begin
                if (!rst_n) begin
                    past_q <= 1'b0;
                end else if (sample_tick) begin
                    past_q <= beyond(reading_in, limit, ch == CH_HIGH);
                end
            end

            // seconds of sustained excursion, saturating so a long one stays alarmed
            always @(posedge clk_in or negedge rst_n) begin
                if (!rst_n) begin
                    secs_q <= {`DELAY_W{1'b0}};
                end else if (!past_q) begin
                    secs_q <= {`DELAY_W{1'b0}};
                end else if (sec_tick && !secs_full) begin
                    secs_q <= secs_q + {{(`DELAY_W-1){1'b0}}, 1'b1};
                end
            end

            // one cycle behind the flag, so a zero delay still passes a register
            always @(posedge clk_in or negedge rst_n) begin
                if (!rst_n) begin
                    alarm_q <= 1'b0;
                end else begin
                    alarm_q <= past_q && delay_met;
                end
            end

            assign chan_lit[ch] = minmax_alarm_output_function_in
                                  && (alarm_q || sys_alarm);
        end
    endgenerate

    // the general alarm led is the or of both channels
    assign led_min_out   = chan_lit[CH_LOW];
    assign led_max_out   = chan_lit[CH_HIGH];
    assign led_alarm_out = chan_lit[CH_LOW] || chan_lit[CH_HIGH];

endmodule // alarm_indicator

// ==== verif/sensor_front_end.sv ====
/* sensor front end model: reading and wiring fault from a set temperature.
   assumes the bench changes its inputs just after a clock edge. */
`timescale 1ns/1ps
module sensor_front_end (
    input  wire logic               clk_in,
    input  wire logic signed [15:0] temp_in,
    input  wire logic               open_in,
    output logic signed [15:0]      reading_out = 16'sh0,
    output logic                    broken_out = 1'b0
);
    // an open wire reads far above range, as a bridge with no sensor would
    always @(posedge clk_in) begin
        reading_out <= open_in ? 16'sh7fff : temp_in;
        broken_out  <= open_in;
    end
endmodule // sensor_front_end

// ==== verif/alarm_indicator_props.sv ====
/* assertions on the alarm block ports.
   assumes the block's defines header is on the include path. */
`timescale 1ns/1ps
`include "alarm_indicator_defines.vh"
module alarm_indicator_props #(parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES) (
    input wire logic                      clk_in, arst_n_in, sensor_fault_in, self_test_fail_in,
    input wire logic                      minmax_alarm_output_function_in, sample_tick_out,
    input wire logic                      led_alarm_out, led_min_out, led_max_out, show_code_out,
    input wire logic signed [`TEMP_W-1:0] reading_in,
    input wire logic [3:0]                fault_code_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    wire t = sample_tick_out && !self_test_fail_in;
    wire ok = t && !sensor_fault_in;
    wire hi = reading_in > `RANGE_MAX_TENTHS;
    wire lo = reading_in < `RANGE_MIN_TENTHS;
    wire fn = minmax_alarm_output_function_in;
    logic [31:0] gap_q;
    // gap stays 0 until the first tick, since that one follows reset
    always @(posedge clk_in or negedge arst_n_in)
        if (!arst_n_in) gap_q <= 32'h0;
        else gap_q <= sample_tick_out ? 32'h1 : gap_q + {31'h0, gap_q != 32'h0};
    property p_gap; sample_tick_out && gap_q != 0 |-> gap_q == SAMPLE_CYCLES; endproperty
    a_gap: assert property (p_gap) else $error("sample spacing");
    property p_sys; sample_tick_out && self_test_fail_in |-> fault_code_out == `CODE_SYSTEM;
    endproperty
    a_sys: assert property (p_sys) else $error("system code");
    property p_sen; t && sensor_fault_in |-> fault_code_out == `CODE_SENSOR; endproperty
    a_sen: assert property (p_sen) else $error("sensor code");
    property p_over; ok && hi |-> fault_code_out == `CODE_OVER_RANGE; endproperty
    a_over: assert property (p_over) else $error("over code");
    property p_under; ok && lo |-> fault_code_out == `CODE_UNDER_RANGE; endproperty
    a_under: assert property (p_under) else $error("under code");
    property p_clr; ok && !hi && !lo |-> fault_code_out == `CODE_NONE && !show_code_out;
    endproperty
    a_clr: assert property (p_clr) else $error("code kept");
    property p_all; sample_tick_out && fn && show_code_out |-> led_min_out && led_max_out
        && led_alarm_out; endproperty
    a_all: assert property (p_all) else $error("fault leds");
    property p_dark; sample_tick_out && !fn |-> !(led_alarm_out || led_min_out || led_max_out);
    endproperty
    a_dark: assert property (p_dark) else $error("leds lit");
    c_over: cover property (ok && hi);
    c_sen: cover property (t && sensor_fault_in);
    c_sys: cover property (sample_tick_out && self_test_fail_in);
endmodule // alarm_indicator_props

// ==== verif/test_alarm_indicator.sv ====
/* self-checking bench for the alarm block, one check set per sample.
   assumes shortened pacing counts handed to the block as parameters. */
`timescale 1ns/1ps
`include "alarm_indicator_defines.vh"
module test_alarm_indicator;
    logic clk_in = 1'b0, arst_n_in = 1'b0, open_q = 1'b0, self_test_fail_in = 1'b0;
    logic minmax_alarm_output_function_in = 1'b0;
    logic signed [15:0] temp_q = 16'sh0, last_q = 16'sh0;
    logic signed [15:0] upper_alarm_limit_in = 16'sh0190, lower_alarm_limit_in = 16'shffce;
    logic [7:0] alarm_delay_seconds_in = 8'h0;
    wire signed [15:0] reading_in, display_value_out;
    wire sensor_fault_in, led_alarm_out, led_min_out, led_max_out, show_code_out, sample_tick_out;
    wire [3:0] fault_code_out;
    int num_errors = 0, comparisons = 0, n;
    // short pacing keeps the run small; the checker takes it over through the bind
    localparam int SC = 40;
    localparam int SEC = 160;
    logic signed [15:0] v;
    always #12.5 clk_in = ~clk_in;
    sensor_front_end sensor_front_end_inst (.clk_in(clk_in), .temp_in(temp_q), .open_in(open_q),
        .reading_out(reading_in), .broken_out(sensor_fault_in));
    alarm_indicator #(.SAMPLE_CYCLES(SC), .SECOND_CYCLES(SEC)) alarm_indicator_inst (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .reading_in(reading_in),
        .sensor_fault_in(sensor_fault_in), .self_test_fail_in(self_test_fail_in),
        .minmax_alarm_output_function_in(minmax_alarm_output_function_in),
        .upper_alarm_limit_in(upper_alarm_limit_in), .lower_alarm_limit_in(lower_alarm_limit_in),
        .alarm_delay_seconds_in(alarm_delay_seconds_in), .led_alarm_out(led_alarm_out),
        .led_min_out(led_min_out), .led_max_out(led_max_out), .fault_code_out(fault_code_out),
        .show_code_out(show_code_out), .display_value_out(display_value_out),
        .sample_tick_out(sample_tick_out));
    function automatic [3:0] want(input logic f, o, input logic signed [15:0] v);
        want = f ? `CODE_SYSTEM : o ? `CODE_SENSOR : v > `RANGE_MAX_TENTHS ? `CODE_OVER_RANGE
            : v < `RANGE_MIN_TENTHS ? `CODE_UNDER_RANGE : `CODE_NONE;
    endfunction
    function automatic [2:0] leds(input logic fn, c, a, input logic signed [15:0] v);
        leds = !fn ? 3'h0 : c ? 3'h7 : !a ? 3'h0 : v > upper_alarm_limit_in ? 3'h5
            : v < lower_alarm_limit_in ? 3'h6 : 3'h0;
    endfunction
    task check(input logic [15:0] seen, exp_v);
        comparisons++;
        if (seen !== exp_v) begin
            num_errors++;
            $display("BAD %0t seen %h want %h", $time, seen, exp_v);
        end
    endtask
    task conclude;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task step(input logic f, o, fn, a, input logic signed [15:0] t);
        logic [3:0] c;
        @(posedge clk_in);
        {self_test_fail_in, open_q, minmax_alarm_output_function_in, temp_q} <= {f, o, fn, t};
        n = 0;
        do begin @(posedge clk_in); #1; n++; end
        while (sample_tick_out !== 1'b1 && n < 2 * SC);
        check(sample_tick_out, 1'b1);
        repeat (2) @(posedge clk_in);
        #1;
        c = want(f, o, t);
        if (c == `CODE_NONE) last_q = t;
        check(fault_code_out, c);
        check(show_code_out, c != `CODE_NONE);
        check(display_value_out, last_q);
        check({led_alarm_out, led_min_out, led_max_out}, leds(fn, c != 0, a, t));
        $display("step done reading %0d code %h", t, c);
    endtask
    initial begin
        n = $urandom(32'hb622);
        repeat (5) @(posedge clk_in);
        arst_n_in <= 1'b1;
        step(0, 0, 1, 1, 16'sh07d1); // one tenth over the top
        step(0, 0, 1, 1, 16'sh07d0);
        step(0, 0, 1, 1, 16'shfe0b);
        step(0, 0, 0, 1, 16'shfe0c);
        step(0, 1, 1, 1, 16'sh0000);
        step(1, 1, 0, 1, 16'sh0000); // self-test beats the sensor fault
        step(1, 0, 1, 1, 16'sh07d1); // self-test beats the range
        step(0, 0, 1, 1, 16'sh01f4); // above the upper limit, no delay
        step(0, 0, 1, 1, 16'shff9c); // below the lower limit, no delay
        step(0, 0, 1, 1, 16'sh0000);
        // a two-second delay holds the alarm off at first, then lets it through
        @(posedge clk_in);
        alarm_delay_seconds_in <= 8'h02;
        step(0, 0, 1, 0, 16'sh01f4);
        repeat (3 * SEC) @(posedge clk_in);
        step(0, 0, 1, 1, 16'sh01f4);
        @(posedge clk_in);
        alarm_delay_seconds_in <= 8'h00;
        step(0, 0, 1, 1, 16'sh07d1);
        // reset in mid-run drops the shown code, the leds and the held value
        @(posedge clk_in);
        arst_n_in <= 1'b0;
        @(posedge clk_in);
        #1;
        check(fault_code_out, `CODE_NONE);
        check(show_code_out, 1'b0);
        check({led_alarm_out, led_min_out, led_max_out}, 3'h0);
        @(posedge clk_in);
        arst_n_in <= 1'b1;
        last_q = 16'sh0;
        repeat (12) begin
            v = 16'($urandom_range(2600)) - 16'sh0230;
            step(1'($urandom_range(7) == 0), 1'($urandom_range(7) == 0),
                1'($urandom_range(1)), 1'b1, v);
        end
        conclude;
    end
    initial begin
        #(25.0 * 5000);
        num_errors++;
        conclude;
    end
endmodule // test_alarm_indicator
bind alarm_indicator alarm_indicator_props #(.SAMPLE_CYCLES(SAMPLE_CYCLES))
    alarm_indicator_props_inst (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .sensor_fault_in(sensor_fault_in),
    .self_test_fail_in(self_test_fail_in),
    .minmax_alarm_output_function_in(minmax_alarm_output_function_in),
    .sample_tick_out(sample_tick_out), .led_alarm_out(led_alarm_out),
    .led_min_out(led_min_out), .led_max_out(led_max_out), .show_code_out(show_code_out),
    .reading_in(reading_in), .fault_code_out(fault_code_out));
